// *** include/oat_pkg.sv ***
package oat_pkg;

  // ==========================================================================
  // Register groups, sizes and clock ratios
  // ==========================================================================
  typedef enum logic [1:0] {OAT_GRP_SYS, OAT_GRP_PERI, OAT_GRP_ROM} oat_grp_t;
  typedef enum logic [1:0] {OAT_SZ_BYTE, OAT_SZ_WORD, OAT_SZ_LONG} oat_size_t;
  typedef enum logic [1:0] {OAT_RATIO_1, OAT_RATIO_2, OAT_RATIO_3} oat_ratio_t;

  localparam int OAT_CNT_W = 5;

  // ==========================================================================
  // Access request carried from a master
  // ==========================================================================
  typedef struct packed {
    oat_grp_t grp;
    oat_size_t size;
    logic write;
    logic conv;
    logic flash;
    logic fetch;
    logic branch;
    logic [2:0] addr_lo;
  } oat_req_t;

  // ==========================================================================
  // System-control group counts
  // ==========================================================================
  localparam logic [4:0] OAT_SYS_CPU_RD_WB = 5'h05;
  localparam logic [4:0] OAT_SYS_CPU_WR_WB = 5'h06;
  localparam logic [4:0] OAT_SYS_CPU_RD_L = 5'h08;
  localparam logic [4:0] OAT_SYS_CPU_WR_L = 5'h09;
  localparam logic [4:0] OAT_SYS_DMA_RD_WB = 5'h03;
  localparam logic [4:0] OAT_SYS_DMA_WR_WB = 5'h04;
  localparam logic [4:0] OAT_SYS_DMA_RD_L = 5'h06;
  localparam logic [4:0] OAT_SYS_DMA_WR_L = 5'h07;

  // ==========================================================================
  // Peripheral group counts (processor base; DMA is two fewer)
  // ==========================================================================
  localparam logic [4:0] OAT_PER_R1_WB = 5'h07;
  localparam logic [4:0] OAT_PER_R1_L = 5'h09;
  localparam logic [4:0] OAT_PER_R2_WB = 5'h09;
  localparam logic [4:0] OAT_PER_R2_L = 5'h0d;
  localparam logic [4:0] OAT_PER_R3_WB = 5'h0c;
  localparam logic [4:0] OAT_PER_R3_L = 5'h12;
  localparam logic [4:0] OAT_PER_DMA_LESS = 5'h02;

  // ==========================================================================
  // ROM counts
  // ==========================================================================
  localparam logic [4:0] OAT_ROM_SLOW = 5'h02;
  localparam logic [4:0] OAT_ROM_SEQ = 5'h01;
  localparam logic [4:0] OAT_ROM_SEQ_ODD = 5'h02;
  localparam logic [4:0] OAT_ROM_BR_HIT = 5'h02;
  localparam logic [4:0] OAT_ROM_BR_MISS = 5'h03;
  localparam logic [4:0] OAT_POSTED_ACK = 5'h01;

endpackage

// *** hdl/oat_access_timer.sv ***
`timescale 1ns/1ps
module oat_access_timer
  import oat_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [4:0] cycles_i,
  output logic busy_o,
  output logic done_o
);

  // ==========================================================================
  // Counts down an access; done pulses in its last cycle
  // ==========================================================================
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start_i) begin
      nxt_cnt = cycles_i;
    end else if (cnt_ff != 5'h00) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (cnt_ff != 5'h00);
  assign done_o = (cnt_ff == 5'h01);

endmodule // oat_access_timer

// *** hdl/oat_onchip_access_timing.sv ***
`timescale 1ns/1ps
// Behaviour
// - Processor register write acknowledged after one cycle
// - Later processor accesses wait for posted write completion
// - System group processor: 5/6 or 8/9 cycles
// - System group DMA: 3/4 or 6/7 cycles
// - Peripheral 1:1: 7/5 or 9/7 cycles
// - Peripheral 1:1/2: phase adds zero or one
// - Peripheral 1:1/3: phase adds zero to two
// - Converter registers byte or word only
// - Flash registers byte access only
// - Low-speed ROM: every access two cycles
// - High-speed sequential fetch one cycle
// - Fetch after 8n+4/8n+6 branch takes two
// - Branch fetch and data read 2-3 cycles
module oat_onchip_access_timing
  import oat_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire oat_ratio_t ratio_i,
  input wire logic rom_fast_i,
  input wire logic cpu_req_i,
  input wire oat_req_t cpu_cmd_i,
  output logic cpu_ready_o,
  output logic cpu_done_o,
  output logic cpu_err_o,
  input wire logic dma_req_i,
  input wire oat_req_t dma_cmd_i,
  output logic dma_ready_o,
  output logic dma_done_o,
  output logic dma_err_o,
  output logic post_busy_o
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ==========================================================================
  // Peripheral clock phase (free running divider of 1, 2 or 3)
  // ==========================================================================
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;

  always_comb begin
    nxt_phase = phase_ff + 2'd1;
    if ((ratio_i == OAT_RATIO_1) ||
        (ratio_i == OAT_RATIO_2 && phase_ff >= 2'd1) ||
        (ratio_i == OAT_RATIO_3 && phase_ff >= 2'd2)) begin
      nxt_phase = 2'd0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 2'd0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ==========================================================================
  // Cycle count for one request
  // ==========================================================================
  function automatic logic [4:0] oat_cycles(input oat_req_t c, input logic is_dma,
                                            input oat_ratio_t r, input logic [1:0] ph,
                                            input logic fast, input logic odd_seq);
    logic lng;
    logic [4:0] n;
    // Converter words ride on the longword timing
    lng = (c.size == OAT_SZ_LONG) ||
          (c.grp == OAT_GRP_PERI && c.conv && c.size == OAT_SZ_WORD);
    n = OAT_ROM_SLOW;
    if (c.grp == OAT_GRP_SYS) begin
      if (!is_dma) begin
        n = lng ? (c.write ? OAT_SYS_CPU_WR_L : OAT_SYS_CPU_RD_L)
                : (c.write ? OAT_SYS_CPU_WR_WB : OAT_SYS_CPU_RD_WB);
      end else begin
        n = lng ? (c.write ? OAT_SYS_DMA_WR_L : OAT_SYS_DMA_RD_L)
                : (c.write ? OAT_SYS_DMA_WR_WB : OAT_SYS_DMA_RD_WB);
      end
    end else if (c.grp == OAT_GRP_PERI) begin
      case (r)
        OAT_RATIO_1: n = lng ? OAT_PER_R1_L : OAT_PER_R1_WB;
        OAT_RATIO_2: n = (lng ? OAT_PER_R2_L : OAT_PER_R2_WB) + {4'h0, ph[0]};
        default: n = (lng ? OAT_PER_R3_L : OAT_PER_R3_WB) + {3'h0, ph};
      endcase
      if (is_dma) begin
        n = n - OAT_PER_DMA_LESS;
      end
    end else if (!fast) begin
      n = OAT_ROM_SLOW;
    end else if (c.fetch && !c.branch) begin
      n = odd_seq ? OAT_ROM_SEQ_ODD : OAT_ROM_SEQ;
    end else begin
      n = c.addr_lo[2] ? OAT_ROM_BR_MISS : OAT_ROM_BR_HIT;
    end
    return n;
  endfunction

  function automatic logic oat_bad_size(input oat_req_t c);
    logic bad;
    bad = 1'b0;
    if (c.grp == OAT_GRP_SYS && c.flash && c.size != OAT_SZ_BYTE) begin
      bad = 1'b1;
    end
    if (c.grp == OAT_GRP_PERI && c.conv && c.size != OAT_SZ_BYTE &&
        c.size != OAT_SZ_WORD) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // ==========================================================================
  // Processor port: posted writes and a stall behind them
  // ==========================================================================
  logic cpu_start;
  logic cpu_busy;
  logic cpu_tdone;
  logic [4:0] cpu_len;
  logic cpu_posted_ff;
  logic nxt_cpu_posted;
  logic cpu_ack_ff;
  logic nxt_cpu_ack;
  logic cpu_err_ff;
  logic nxt_cpu_err;
  logic odd_ff;
  logic nxt_odd;
  logic cpu_bad;
  logic cpu_reg;

  assign cpu_bad = oat_bad_size(cpu_cmd_i);
  assign cpu_reg = (cpu_cmd_i.grp != OAT_GRP_ROM);
  assign cpu_len = oat_cycles(cpu_cmd_i, 1'b0, ratio_i, phase_ff, rom_fast_i, odd_ff);
  // Any new access waits while the timer runs, which also covers posted writes
  assign cpu_ready_o = !cpu_busy;
  assign cpu_start = cpu_req_i && cpu_ready_o && !cpu_bad;

  always_comb begin
    nxt_cpu_posted = cpu_posted_ff;
    nxt_cpu_ack = 1'b0;
    nxt_cpu_err = cpu_req_i && cpu_ready_o && cpu_bad;
    nxt_odd = odd_ff;
    if (cpu_tdone) begin
      nxt_cpu_posted = 1'b0;
    end
    if (cpu_start && cpu_reg && cpu_cmd_i.write) begin
      nxt_cpu_posted = 1'b1;
      nxt_cpu_ack = 1'b1;
    end
    if (cpu_start && cpu_cmd_i.grp == OAT_GRP_ROM && cpu_cmd_i.fetch) begin
      nxt_odd = rom_fast_i && cpu_cmd_i.branch && cpu_cmd_i.addr_lo[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_posted_ff <= 1'b0;
      cpu_ack_ff <= 1'b0;
      cpu_err_ff <= 1'b0;
      odd_ff <= 1'b0;
    end else begin
      cpu_posted_ff <= nxt_cpu_posted;
      cpu_ack_ff <= nxt_cpu_ack;
      cpu_err_ff <= nxt_cpu_err;
      odd_ff <= nxt_odd;
    end
  end

  oat_access_timer u_cpu_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .start_i(cpu_start),
    .cycles_i(cpu_len),
    .busy_o(cpu_busy),
    .done_o(cpu_tdone)
  );

  // Posted writes answer early; everything else answers at the last cycle
  assign cpu_done_o = cpu_ack_ff || (cpu_tdone && !cpu_posted_ff);
  assign cpu_err_o = cpu_err_ff;
  assign post_busy_o = cpu_posted_ff;

  // ==========================================================================
  // DMA port
  // ==========================================================================
  logic dma_start;
  logic dma_busy;
  logic [4:0] dma_len;
  logic dma_bad;
  logic dma_err_ff;
  logic nxt_dma_err;

  assign dma_bad = oat_bad_size(dma_cmd_i);
  assign dma_len = oat_cycles(dma_cmd_i, 1'b1, ratio_i, phase_ff, rom_fast_i, 1'b0);
  assign dma_ready_o = !dma_busy;
  assign dma_start = dma_req_i && dma_ready_o && !dma_bad;

  always_comb begin
    nxt_dma_err = dma_req_i && dma_ready_o && dma_bad;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dma_err_ff <= 1'b0;
    end else begin
      dma_err_ff <= nxt_dma_err;
    end
  end

  oat_access_timer u_dma_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .start_i(dma_start),
    .cycles_i(dma_len),
    .busy_o(dma_busy),
    .done_o(dma_done_o)
  );

  assign dma_err_o = dma_err_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_posted_ack_one: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_reg && cpu_cmd_i.write) |=> cpu_done_o)
    else $error("posted write not acknowledged after one cycle");

  a_stall_behind_post: assert property (@(posedge clk_i) disable iff (!rst_n)
    post_busy_o |-> !cpu_ready_o)
    else $error("access accepted during posted write");

  a_sys_cpu_word_rd: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_SYS && !cpu_cmd_i.write &&
     cpu_cmd_i.size != OAT_SZ_LONG) |=> !cpu_done_o [*4] ##1 cpu_done_o)
    else $error("system read not five cycles");

  a_sys_dma_long_wr: assert property (@(posedge clk_i) disable iff (!rst_n)
    (dma_start && dma_cmd_i.grp == OAT_GRP_SYS && dma_cmd_i.write &&
     dma_cmd_i.size == OAT_SZ_LONG) |=> !dma_done_o [*6] ##1 dma_done_o)
    else $error("dma system longword write not seven cycles");

  a_peri_ratio_one: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_PERI && ratio_i == OAT_RATIO_1 &&
     cpu_cmd_i.size == OAT_SZ_LONG && !cpu_cmd_i.write) |=> !cpu_done_o [*8] ##1 cpu_done_o)
    else $error("peripheral longword not nine cycles");

  a_peri_ratio_three: assert property (@(posedge clk_i) disable iff (!rst_n)
    (dma_start && dma_cmd_i.grp == OAT_GRP_PERI && ratio_i == OAT_RATIO_3 &&
     !dma_cmd_i.conv && dma_cmd_i.size != OAT_SZ_LONG) |=>
    !dma_done_o [*8] ##1 !dma_done_o ##[1:3] dma_done_o)
    else $error("dma peripheral access outside 10 to 12");

  a_peri_half_ratio: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_PERI && ratio_i == OAT_RATIO_2 &&
     cpu_cmd_i.size == OAT_SZ_LONG && !cpu_cmd_i.write) |=>
    !cpu_done_o [*8] ##1 !cpu_done_o [*4] ##[1:2] cpu_done_o)
    else $error("peripheral longword at half ratio not 13 or 14 cycles");

  a_conv_word_long: assert property (@(posedge clk_i) disable iff (!rst_n)
    (dma_start && dma_cmd_i.grp == OAT_GRP_PERI && dma_cmd_i.conv &&
     dma_cmd_i.size == OAT_SZ_WORD && ratio_i == OAT_RATIO_1) |=>
    !dma_done_o [*6] ##1 dma_done_o)
    else $error("converter word access not on longword timing");

  a_conv_long_err: assert property (@(posedge clk_i) disable iff (!rst_n)
    (dma_req_i && dma_ready_o && dma_cmd_i.grp == OAT_GRP_PERI && dma_cmd_i.conv &&
     dma_cmd_i.size == OAT_SZ_LONG) |=> (dma_err_o && !dma_busy))
    else $error("converter longword access not refused");

  a_rom_slow_two: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_ROM && !rom_fast_i) |=> !cpu_done_o ##1 cpu_done_o)
    else $error("slow rom access not two cycles");

  a_rom_seq_one: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_ROM && rom_fast_i && cpu_cmd_i.fetch &&
     !cpu_cmd_i.branch && !odd_ff) |=> cpu_done_o)
    else $error("sequential fetch not one cycle");

  a_rom_after_odd: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_ROM && rom_fast_i && cpu_cmd_i.fetch &&
     !cpu_cmd_i.branch && odd_ff) |=> !cpu_done_o ##1 cpu_done_o)
    else $error("fetch after odd branch target not two cycles");

  a_rom_branch_fetch: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_start && cpu_cmd_i.grp == OAT_GRP_ROM && rom_fast_i &&
     (cpu_cmd_i.branch || !cpu_cmd_i.fetch)) |=> !cpu_done_o ##[1:2] cpu_done_o)
    else $error("branch fetch or data read outside 2 to 3 cycles");

  a_bad_size_err: assert property (@(posedge clk_i) disable iff (!rst_n)
    (cpu_req_i && cpu_ready_o && cpu_cmd_i.grp == OAT_GRP_SYS && cpu_cmd_i.flash &&
     cpu_cmd_i.size != OAT_SZ_BYTE) |=> (cpu_err_o && !cpu_busy))
    else $error("flash register wide access not refused");

endmodule // oat_onchip_access_timing

// *** tb/oat_master_model.sv ***
`timescale 1ns/1ps
module oat_master_model
  import oat_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire oat_req_t cmd_i,
  input wire logic ready_i,
  input wire logic done_i,
  input wire logic err_i,
  output logic req_o = 1'b0,
  output oat_req_t cmd_o = '0,
  output logic fin_o = 1'b1,
  output logic err_o = 1'b0,
  output logic [7:0] lat_o = 8'h00,
  output logic [7:0] wt_o = 8'h00
);
  // ==========================================================================
  // Request holder and latency counter
  // ==========================================================================
  logic run = 1'b0;
  logic [7:0] cnt = 8'h00;
  always @(posedge clk_i) begin
    if (go_i) begin
      req_o <= 1'b1;
      cmd_o <= cmd_i;
      fin_o <= 1'b0;
      wt_o <= 8'h00;
    end else if (req_o) begin
      if (ready_i) begin
        req_o <= 1'b0;
        // Released command lines do not keep their last value
        cmd_o <= oat_req_t'(~cmd_o);
        run <= 1'b1;
        cnt <= 8'h01;
      end else begin
        wt_o <= wt_o + 8'h01;
      end
    end else if (run) begin
      // Nothing further is issued until completion is seen
      if (done_i || err_i) begin
        run <= 1'b0;
        fin_o <= 1'b1;
        err_o <= err_i;
        lat_o <= cnt;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // oat_master_model

// *** tb/oat_onchip_access_timing_test.sv ***
`timescale 1ns/1ps
module oat_onchip_access_timing_test;
  import oat_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  oat_ratio_t ratio_i = OAT_RATIO_1;
  logic rom_fast_i = 1'b0;
  logic go[2] = '{1'b0, 1'b0};
  oat_req_t cmd[2] = '{'0, '0};
  logic req[2], rdy[2], dne[2], er[2], fin[2], mer[2];
  oat_req_t mcmd[2];
  logic [7:0] lat[2], wt[2];
  logic post_busy_o;
  int failures = 0;
  int check_count = 0;
  always #4 clk_i = ~clk_i;

  oat_onchip_access_timing uut (.clk_i(clk_i), .rstn_i(rstn_i), .ratio_i(ratio_i),
    .rom_fast_i(rom_fast_i), .cpu_req_i(req[0]), .cpu_cmd_i(mcmd[0]), .cpu_ready_o(rdy[0]),
    .cpu_done_o(dne[0]), .cpu_err_o(er[0]), .dma_req_i(req[1]), .dma_cmd_i(mcmd[1]),
    .dma_ready_o(rdy[1]), .dma_done_o(dne[1]), .dma_err_o(er[1]), .post_busy_o(post_busy_o));
  for (genvar g = 0; g < 2; g++) begin : gm
    oat_master_model mm (.clk_i(clk_i), .go_i(go[g]), .cmd_i(cmd[g]), .ready_i(rdy[g]),
      .done_i(dne[g]), .err_i(er[g]), .req_o(req[g]), .cmd_o(mcmd[g]), .fin_o(fin[g]),
      .err_o(mer[g]), .lat_o(lat[g]), .wt_o(wt[g]));
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic final_report();
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic oat_req_t mk(input oat_grp_t g, input oat_size_t s, input logic w,
    input logic [3:0] f, input logic [2:0] a);
    mk = '{g, s, w, f[3], f[2], f[1], f[0], a};
  endfunction

  task automatic xfer(input int m, input oat_req_t c);
    int i;
    @(posedge clk_i);
    go[m] <= 1'b1;
    cmd[m] <= c;
    @(posedge clk_i);
    go[m] <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_i);
      #1;
      if (fin[m] === 1'b1) break;
    end
    if (i == 60) begin
      failures++;
      final_report();
    end
  endtask

  // Counts cycles the posted write stays in flight after its acknowledge cycle
  task automatic wait_post(input int n);
    int k;
    k = 0;
    while (post_busy_o === 1'b1 && k < 40) begin
      k++;
      @(posedge clk_i);
      #1;
    end
    check(8'(k), 8'(n - 1));
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_sys();
    int n;
    for (int m = 0; m < 2; m++) for (int s = 0; s < 3; s++) for (int w = 0; w < 2; w++) begin
      n = (s == 2 ? 8 : 5) + w - 2 * m;
      xfer(m, mk(OAT_GRP_SYS, oat_size_t'(s), w[0], 4'h0, 3'h0));
      if (m == 0 && w == 1) begin
        check(lat[0], 8'h01);
        wait_post(n);
      end else if (m == 0) begin
        check(lat[0], 8'(n));
      end else begin
        check(lat[1], 8'(n));
      end
    end
  endtask

  task automatic t_peri();
    int lo;
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_i);
      ratio_i <= oat_ratio_t'(r);
      for (int m = 0; m < 2; m++) for (int s = 0; s < 3; s += 2) for (int k = 0; k < 6; k++) begin
        lo = (r == 0 ? 7 : r == 1 ? 9 : 12) + (s == 2 ? 2 + 2 * r : 0) - 2 * m;
        if (m == 0 && k[0]) continue;
        xfer(m, mk(OAT_GRP_PERI, oat_size_t'(s), k[0], 4'h0, 3'h0));
        check({7'h00, lat[m] >= lo && lat[m] <= lo + r}, 8'h01);
      end
    end
  endtask

  task automatic t_err();
    @(posedge clk_i);
    ratio_i <= OAT_RATIO_1;
    for (int m = 0; m < 2; m++) begin
      xfer(m, mk(OAT_GRP_SYS, OAT_SZ_WORD, 1'b0, 4'h4, 3'h0));
      check({mer[m], lat[m]}, {1'b1, 8'h01});
      xfer(m, mk(OAT_GRP_PERI, OAT_SZ_LONG, 1'b0, 4'h8, 3'h0));
      check({mer[m], lat[m]}, {1'b1, 8'h01});
      xfer(m, mk(OAT_GRP_SYS, OAT_SZ_BYTE, 1'b0, 4'h4, 3'h0));
      check({mer[m], lat[m]}, {1'b0, 8'(5 - 2 * m)});
      xfer(m, mk(OAT_GRP_PERI, OAT_SZ_BYTE, 1'b0, 4'h8, 3'h0));
      check({mer[m], lat[m]}, {1'b0, 8'(7 - 2 * m)});
      xfer(m, mk(OAT_GRP_PERI, OAT_SZ_WORD, 1'b0, 4'h8, 3'h0));
      check({mer[m], lat[m]}, {1'b0, 8'(9 - 2 * m)});
    end
  endtask

  task automatic rom(input int m, input logic fast, input logic [3:0] f, input logic [2:0] a,
    input int exp);
    @(posedge clk_i);
    rom_fast_i <= fast;
    xfer(m, mk(OAT_GRP_ROM, OAT_SZ_LONG, 1'b0, f, a));
    check(lat[m], 8'(exp));
  endtask

  task automatic t_rom();
    rom(0, 1'b0, 4'h2, 3'h0, 2);
    rom(0, 1'b0, 4'h3, 3'h4, 2);
    rom(0, 1'b0, 4'h0, 3'h4, 2);
    rom(0, 1'b1, 4'h3, 3'h4, 3);
    rom(0, 1'b1, 4'h2, 3'h0, 2);
    rom(0, 1'b1, 4'h2, 3'h0, 1);
    rom(0, 1'b1, 4'h3, 3'h6, 3);
    rom(0, 1'b1, 4'h2, 3'h0, 2);
    rom(0, 1'b1, 4'h3, 3'h0, 2);
    rom(0, 1'b1, 4'h2, 3'h0, 1);
    rom(0, 1'b1, 4'h0, 3'h4, 3);
    rom(1, 1'b1, 4'h0, 3'h0, 2);
  endtask

  task automatic t_post();
    xfer(0, mk(OAT_GRP_SYS, OAT_SZ_LONG, 1'b1, 4'h0, 3'h0));
    check({post_busy_o, rdy[0]}, 2'b10);
    xfer(0, mk(OAT_GRP_PERI, OAT_SZ_BYTE, 1'b0, 4'h0, 3'h0));
    check({7'h00, wt[0] > 8'h00}, 8'h01);
    check({post_busy_o, lat[0]}, {1'b0, 8'h07});
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_sys();
    t_peri();
    t_err();
    t_rom();
    t_post();
    final_report();
  end
endmodule // oat_onchip_access_timing_test
